/* rtccc_pkg.sv */
//------------------------------------------------------------------------------
// Purpose: shared constants of the rtc calendar counter chain
// Assumes: 32-bit register port with byte addresses
// Notes:   bcd values are kept at the width of the counter they load
//------------------------------------------------------------------------------
package rtccc_pkg;

   //---------------------------------------------------------------------------
   // register byte addresses
   //---------------------------------------------------------------------------
   localparam logic [31:0] ADDR_CTRL = 32'h4000_5200;
   localparam logic [31:0] ADDR_CORR = 32'h4000_5204;
   localparam logic [31:0] ADDR_SUB = 32'h4000_5208;
   localparam logic [31:0] ADDR_SEC = 32'h4000_520C;
   localparam logic [31:0] ADDR_MIN = 32'h4000_5210;
   localparam logic [31:0] ADDR_HOUR = 32'h4000_5214;
   localparam logic [31:0] ADDR_DAY = 32'h4000_5218;
   localparam logic [31:0] ADDR_WEEK = 32'h4000_521C;

   //---------------------------------------------------------------------------
   // field positions
   //---------------------------------------------------------------------------
   localparam int CTRL_EN_BIT = 15;
   localparam int CTRL_FMT_BIT = 10;
   localparam int CTRL_HSTAT_BIT = 1;
   localparam int CTRL_HREQ_BIT = 0;
   localparam int CORR_INTV_BIT = 7;
   localparam int CORR_SIGN_BIT = 6;
   localparam int PM_BIT = 5;

   //---------------------------------------------------------------------------
   // reset values
   //---------------------------------------------------------------------------
   localparam logic [15:0] RST_SUB = 16'h0000;
   localparam logic [6:0] RST_SEC = 7'h00;
   localparam logic [6:0] RST_MIN = 7'h00;
   localparam logic [5:0] RST_HOUR = 6'h12;
   localparam logic [5:0] RST_DAY = 6'h01;
   localparam logic [2:0] RST_WEEK = 3'h0;
   localparam logic [7:0] RST_CORR = 8'h00;

   //---------------------------------------------------------------------------
   // timing: oscillator counts per nominal second
   //---------------------------------------------------------------------------
   localparam int SUBSEC_COUNT_DEF = 32768;

   //---------------------------------------------------------------------------
   // bcd landmarks
   //---------------------------------------------------------------------------
   localparam logic [6:0] BCD_59 = 7'h59;
   localparam logic [6:0] MARK_00 = 7'h00;
   localparam logic [6:0] MARK_20 = 7'h20;
   localparam logic [6:0] MARK_40 = 7'h40;
   localparam logic [5:0] H24_LAST = 6'h23;
   localparam logic [5:0] H12_MIDNIGHT = 6'h12;
   localparam logic [5:0] H12_AM_LAST = 6'h11;
   localparam logic [5:0] H12_NOON = 6'h32;
   localparam logic [5:0] H12_PM_FIRST = 6'h21;
   localparam logic [5:0] H12_PM_LAST = 6'h31;
   localparam logic [5:0] H12_ONE = 6'h01;
   localparam logic [5:0] H24_ZERO = 6'h00;
   localparam logic [5:0] DAY_FIRST = 6'h01;
   localparam logic [5:0] DAY_31 = 6'h31;
   localparam logic [5:0] DAY_30 = 6'h30;
   localparam logic [5:0] DAY_29 = 6'h29;
   localparam logic [5:0] DAY_28 = 6'h28;
   localparam logic [4:0] MON_FEB = 5'h02;
   localparam logic [4:0] MON_APR = 5'h04;
   localparam logic [4:0] MON_JUN = 5'h06;
   localparam logic [4:0] MON_SEP = 5'h09;
   localparam logic [4:0] MON_NOV = 5'h11;
   localparam logic [2:0] WEEK_LAST = 3'h6;

   //---------------------------------------------------------------------------
   // legal write ranges, one byte per checker, index 0 in the low byte
   //---------------------------------------------------------------------------
   localparam int RG_SEC = 0;
   localparam int RG_MIN = 1;
   localparam int RG_H24 = 2;
   localparam int RG_H12A = 3;
   localparam int RG_H12B = 4;
   localparam int RG_DAY = 5;
   localparam int RG_WEEK = 6;
   localparam int RG_N = 7;
   localparam logic [55:0] RANGE_LO = 56'h00_01_21_01_00_00_00;
   localparam logic [55:0] RANGE_HI = 56'h06_31_32_12_23_59_59;

   // hold handshake of the counter chain
   typedef enum logic [0:0] {
      RTCCC_RUN = 1'b0,
      RTCCC_HELD = 1'b1
   } rtccc_hold_t;

endpackage

/* rtccc_bcd_range.sv */
//------------------------------------------------------------------------------
// Purpose: checks that a byte is valid bcd inside an inclusive range
// Assumes: lo and hi are themselves valid bcd
// Notes:   bcd ordering matches plain byte ordering, so a byte compare suffices
//------------------------------------------------------------------------------
`timescale 1ns/100ps
module rtccc_bcd_range #(
   parameter logic [7:0] LO = 8'h00,
   parameter logic [7:0] HI = 8'h59
) (
   // value under test
   input wire logic [7:0] value_i,
   // verdict
   output logic legal_o
);
   // both digits decimal and the byte inside the window
   assign legal_o = (value_i[3:0] <= 4'h9) && (value_i[7:4] <= 4'h9) &&
                    (value_i >= LO) && (value_i <= HI);
endmodule // rtccc_bcd_range

/* rtccc_corr_calc.sv */
//------------------------------------------------------------------------------
// Purpose: turns the correction setting into the sub-second terminal count
// Assumes: seconds value is the live bcd seconds count
// Notes:   output is purely combinational; the caller registers the effect
//------------------------------------------------------------------------------
`timescale 1ns/100ps
module rtccc_corr_calc
   import rtccc_pkg::*;
#(
   parameter int SUBSEC_COUNT = SUBSEC_COUNT_DEF
) (
   // setting and current second
   input wire logic [7:0] corr_setting_i,
   input wire logic [6:0] seconds_bcd_i,
   // result
   output logic [16:0] terminal_o
);
   logic correction_interval_sel;
   logic correction_sign;
   logic [5:0] correction_magnitude;
   logic instant;
   logic active;
   logic [7:0] step;
   logic [16:0] nominal;

   assign correction_interval_sel = corr_setting_i[CORR_INTV_BIT];
   assign correction_sign = corr_setting_i[CORR_SIGN_BIT];
   assign correction_magnitude = corr_setting_i[5:0];

   // correction instants: every 20 s or only at the minute
   assign instant = correction_interval_sel ? (seconds_bcd_i == MARK_00) : // [RULE1]
                    (seconds_bcd_i == MARK_00) || (seconds_bcd_i == MARK_20) ||
                    (seconds_bcd_i == MARK_40);

   // small magnitudes switch correction off whatever the sign
   assign active = instant && (correction_magnitude[5:1] != 5'h00); // [RULE4]

   // step is an even count 2..124 in either direction
   always_comb begin
      if (!correction_sign) begin
         step = 8'(({2'b00, correction_magnitude} - 8'h01) << 1); // [RULE2] [RULE5]
      end else begin
         step = 8'(({2'b00, ~correction_magnitude} + 8'h01) << 1); // [RULE3] [RULE5]
      end
   end

   assign nominal = 17'(SUBSEC_COUNT - 1);

   // positive value is added to the count, i.e. the second ends earlier
   always_comb begin
      if (!active) begin
         terminal_o = nominal;
      end else if (!correction_sign) begin
         terminal_o = nominal - {9'h000, step}; // [RULE21]
      end else begin
         terminal_o = nominal + {9'h000, step}; // [RULE21]
      end
   end
endmodule // rtccc_corr_calc

/* rtccc_chain.sv */
//------------------------------------------------------------------------------
// Purpose: bcd time-keeping chain: sub-second, seconds, minutes, hours, day,
//          weekday, with time error correction and a register port
// Assumes: clk_i is the oscillator clock; month and leap inputs come from
//          calendar logic on the same clock
// Notes:   the sub-second counter keeps running while the chain is held
//------------------------------------------------------------------------------
// Functional notes
// RULE1 - interval bit 0 corrects at seconds 00, 20, 40; bit 1 only at 00
// RULE2 - positive sign: correction equals (magnitude minus one) times two
// RULE3 - negative sign: correction equals (inverted magnitude plus one) times two
// RULE4 - upper five magnitude bits all zero means no correction at all
// RULE5 - correction steps are even, 2 to 124 either direction
// RULE6 - software avoids writing the correction setting during correction seconds
// RULE7 - sub-second count is 16 bits and may reach 8000H or above
// RULE8 - every seconds write clears the sub-second count
// RULE9 - software must not trust sub-second reads while counting runs
// RULE10 - seconds count 00 to 59 bcd, step on sub-second overflow
// RULE11 - out-of-range bcd writes to seconds, minutes, hours, day are ignored
// RULE12 - minutes count 00 to 59 bcd, step on seconds rollover
// RULE13 - a write to minutes, hours or day wins over an arriving carry
// RULE14 - hours step on minutes rollover; 24-hour form spans 00 to 23
// RULE15 - 12-hour form: bit 5 is pm, midnight 12H, noon 32H
// RULE16 - software writes hours legal for the selected format
// RULE17 - day counts 01 to 31 bcd, step on hours rollover
// RULE18 - day wraps at month length, february by leap year
// RULE19 - weekday 0 to 6 steps with the day, not derived from the date
// RULE20 - hour format bit 1 selects 24-hour, 0 selects 12-hour
// RULE21 - sub-second counts clocks, overflows once a second, correction added
//------------------------------------------------------------------------------
`timescale 1ns/100ps
module rtccc_chain
   import rtccc_pkg::*;
#(
   parameter int SUBSEC_COUNT = SUBSEC_COUNT_DEF
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // register port
   input wire logic [31:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // calendar context
   input wire logic [4:0] month_bcd_i,
   input wire logic leap_year_i,
   output logic day_overflow_o
);

   //---------------------------------------------------------------------------
   // helper functions
   //---------------------------------------------------------------------------
   // bcd increment of one byte, no wrap handling
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
   endfunction
   function automatic logic [4:0] bcd_to_bin(input logic [5:0] v);
      bcd_to_bin = 5'(v[5:4]) * 5'd10 + 5'(v[3:0]);
   endfunction
   function automatic logic [5:0] bin_to_bcd(input logic [4:0] b);
      if (b >= 5'd20) begin
         bin_to_bcd = {2'd2, 4'(b - 5'd20)};
      end else if (b >= 5'd10) begin
         bin_to_bcd = {2'd1, 4'(b - 5'd10)};
      end else begin
         bin_to_bcd = {2'd0, 4'(b)};
      end
   endfunction
   // 24-hour bcd to 12-hour bcd with pm flag
   function automatic logic [5:0] hour_to12(input logic [5:0] h);
      logic [4:0] b;
      logic pm;
      logic [5:0] r;
      b = bcd_to_bin(h);
      pm = (b >= 5'd12);
      b = pm ? b - 5'd12 : b;
      b = (b == 5'd0) ? 5'd12 : b;
      r = bin_to_bcd(b);
      r[PM_BIT] = pm;
      hour_to12 = r;
   endfunction
   // 12-hour bcd with pm flag to 24-hour bcd
   function automatic logic [5:0] hour_to24(input logic [5:0] h);
      logic [4:0] b;
      b = bcd_to_bin({1'b0, h[4:0]});
      b = (b == 5'd12) ? 5'd0 : b;
      b = h[PM_BIT] ? b + 5'd12 : b;
      hour_to24 = bin_to_bcd(b);
   endfunction

   //---------------------------------------------------------------------------
   // registers and nets
   //---------------------------------------------------------------------------
   logic [15:0] sub_r, sub_nxt;
   logic [6:0] sec_r, sec_nxt, min_r, min_nxt;
   logic [5:0] hour_r, hour_nxt, day_r, day_nxt, day_last;
   logic [2:0] week_r, week_nxt;
   logic [7:0] corr_r;
   logic count_en_r, hour_format_sel_r, hold_stat_r, pending_r;
   rtccc_hold_t hold_req_r;
   logic [16:0] terminal;
   logic [RG_N-1:0] legal;
   logic wr_ctrl, wr_corr, wr_sec, wr_min, wr_hour, wr_day, wr_week;
   logic hour_ok, fmt_change, sub_ovf, tick;
   logic sec_carry, min_carry, hour_last, hour_carry, day_carry;

   //---------------------------------------------------------------------------
   // write decode and range checks
   //---------------------------------------------------------------------------
   assign wr_ctrl = wr_i && (addr_i == ADDR_CTRL);
   assign wr_corr = wr_i && (addr_i == ADDR_CORR);
   assign wr_sec = wr_i && (addr_i == ADDR_SEC);
   assign wr_min = wr_i && (addr_i == ADDR_MIN);
   assign wr_hour = wr_i && (addr_i == ADDR_HOUR);
   assign wr_day = wr_i && (addr_i == ADDR_DAY);
   assign wr_week = wr_i && (addr_i == ADDR_WEEK);

   // one checker per counter range, all looking at the low data byte
   for (genvar g = 0; g < RG_N; g++) begin : g_range
      rtccc_bcd_range #(
         .LO(RANGE_LO[g*8 +: 8]),
         .HI(RANGE_HI[g*8 +: 8])
      ) u_range (
         .value_i(wdata_i[7:0]),
         .legal_o(legal[g])
      );
   end

   // legal hour set depends on the current format
   assign hour_ok = hour_format_sel_r ? legal[RG_H24] : // [RULE11]
                    (legal[RG_H12A] || legal[RG_H12B]);
   assign fmt_change = wr_ctrl && (wdata_i[CTRL_FMT_BIT] != hour_format_sel_r);

   //---------------------------------------------------------------------------
   // control and correction setting
   //---------------------------------------------------------------------------
   // hold status lags the request by one clock, software polls it
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         count_en_r <= 1'b0;
         hour_format_sel_r <= 1'b0;
         hold_req_r <= RTCCC_RUN;
         hold_stat_r <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            count_en_r <= wdata_i[CTRL_EN_BIT];
            hour_format_sel_r <= wdata_i[CTRL_FMT_BIT]; // [RULE20]
            hold_req_r <= wdata_i[CTRL_HREQ_BIT] ? RTCCC_HELD : RTCCC_RUN;
         end
         hold_stat_r <= (hold_req_r == RTCCC_HELD);
      end
   end

   // no write guard: avoiding the correction seconds is left to software
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         corr_r <= RST_CORR;
      end else if (wr_corr) begin
         corr_r <= wdata_i[7:0];
      end
   end

   rtccc_corr_calc #(
      .SUBSEC_COUNT(SUBSEC_COUNT)
   ) u_corr (
      .corr_setting_i(corr_r),
      .seconds_bcd_i(sec_r),
      .terminal_o(terminal)
   );

   //---------------------------------------------------------------------------
   // sub-second counter
   //---------------------------------------------------------------------------
   // compare at 17 bits so a lengthened second can run past 7FFFH
   assign sub_ovf = count_en_r && ({1'b0, sub_r} >= terminal) && !wr_sec; // [RULE21]
   always_comb begin
      if (wr_sec) begin
         sub_nxt = RST_SUB; // [RULE8]
      end else if (!count_en_r) begin
         sub_nxt = sub_r;
      end else if (sub_ovf) begin
         sub_nxt = RST_SUB;
      end else begin
         sub_nxt = sub_r + 16'h0001; // [RULE7] [RULE21]
      end
   end
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         sub_r <= RST_SUB;
      end else begin
         sub_r <= sub_nxt;
      end
   end

   // an overflow seen while held is replayed when the hold is released;
   // a seconds write throws it away since the sub-second count restarts
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         pending_r <= 1'b0;
      end else if (wr_sec) begin
         pending_r <= 1'b0;
      end else if (sub_ovf && (hold_req_r == RTCCC_HELD)) begin
         pending_r <= 1'b1;
      end else if (hold_req_r == RTCCC_RUN) begin
         pending_r <= 1'b0;
      end
   end

   //---------------------------------------------------------------------------
   // carry chain
   //---------------------------------------------------------------------------
   assign tick = (sub_ovf || pending_r) && (hold_req_r == RTCCC_RUN) && !wr_sec;
   assign sec_carry = tick && (sec_r == BCD_59);
   assign min_carry = sec_carry && (min_r == BCD_59) && !wr_min; // [RULE13]
   assign hour_last = hour_format_sel_r ? (hour_r == H24_LAST) : (hour_r == H12_PM_LAST);
   // a format change in the same clock swallows the carry
   assign hour_carry = min_carry && hour_last && !wr_hour && !fmt_change; // [RULE13]

   // month length picks the day wrap point
   always_comb begin
      if (month_bcd_i == MON_FEB) begin
         day_last = leap_year_i ? DAY_29 : DAY_28; // [RULE18]
      end else if ((month_bcd_i == MON_APR) || (month_bcd_i == MON_JUN) ||
                   (month_bcd_i == MON_SEP) || (month_bcd_i == MON_NOV)) begin
         day_last = DAY_30; // [RULE18]
      end else begin
         day_last = DAY_31; // [RULE18]
      end
   end
   assign day_carry = hour_carry && (day_r >= day_last) && !wr_day;

   //---------------------------------------------------------------------------
   // seconds and minutes
   //---------------------------------------------------------------------------
   always_comb begin
      if (wr_sec && legal[RG_SEC]) begin
         sec_nxt = wdata_i[6:0]; // [RULE11]
      end else if (sec_carry) begin
         sec_nxt = MARK_00; // [RULE10]
      end else if (tick) begin
         sec_nxt = 7'(bcd_inc({1'b0, sec_r})); // [RULE10]
      end else begin
         sec_nxt = sec_r;
      end
   end
   always_comb begin
      if (wr_min && legal[RG_MIN]) begin
         min_nxt = wdata_i[6:0]; // [RULE11] [RULE13]
      end else if (wr_min || !sec_carry) begin
         min_nxt = min_r;
      end else if (min_r == BCD_59) begin
         min_nxt = MARK_00; // [RULE12]
      end else begin
         min_nxt = 7'(bcd_inc({1'b0, min_r})); // [RULE12]
      end
   end

   //---------------------------------------------------------------------------
   // hours
   //---------------------------------------------------------------------------
   always_comb begin
      if (wr_hour) begin
         hour_nxt = hour_ok ? wdata_i[5:0] : hour_r; // [RULE11] [RULE13]
      end else if (fmt_change) begin
         // keep the same time of day across a format switch
         hour_nxt = wdata_i[CTRL_FMT_BIT] ? hour_to24(hour_r) : hour_to12(hour_r); // [RULE20]
      end else if (!min_carry) begin
         hour_nxt = hour_r;
      end else if (hour_format_sel_r) begin
         hour_nxt = hour_last ? H24_ZERO : 6'(bcd_inc({2'b00, hour_r})); // [RULE14]
      end else begin
         case (hour_r)
            H12_AM_LAST: hour_nxt = H12_NOON; // [RULE15]
            H12_MIDNIGHT: hour_nxt = H12_ONE; // [RULE15]
            H12_NOON: hour_nxt = H12_PM_FIRST; // [RULE15]
            H12_PM_LAST: hour_nxt = H12_MIDNIGHT; // [RULE15]
            default: hour_nxt = 6'(bcd_inc({2'b00, hour_r})); // [RULE14]
         endcase
      end
   end

   //---------------------------------------------------------------------------
   // day of month and weekday
   //---------------------------------------------------------------------------
   always_comb begin
      if (wr_day) begin
         day_nxt = legal[RG_DAY] ? wdata_i[5:0] : day_r; // [RULE11] [RULE13]
      end else if (day_carry) begin
         day_nxt = DAY_FIRST; // [RULE18]
      end else if (hour_carry) begin
         day_nxt = 6'(bcd_inc({2'b00, day_r})); // [RULE17]
      end else begin
         day_nxt = day_r;
      end
   end

   // weekday only follows the day step, never the date
   always_comb begin
      if (wr_week) begin
         week_nxt = legal[RG_WEEK] ? wdata_i[2:0] : week_r;
      end else if (hour_carry) begin
         week_nxt = (week_r == WEEK_LAST) ? RST_WEEK : week_r + 3'h1; // [RULE19]
      end else begin
         week_nxt = week_r;
      end
   end

   // all calendar counters load together
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         sec_r <= RST_SEC;
         min_r <= RST_MIN;
         hour_r <= RST_HOUR;
         day_r <= RST_DAY;
         week_r <= RST_WEEK;
      end else begin
         sec_r <= sec_nxt;
         min_r <= min_nxt;
         hour_r <= hour_nxt;
         day_r <= day_nxt;
         week_r <= week_nxt;
      end
   end

   // one-clock pulse towards the month counter
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         day_overflow_o <= 1'b0;
      end else begin
         day_overflow_o <= day_carry;
      end
   end

   //---------------------------------------------------------------------------
   // read port
   //---------------------------------------------------------------------------
   // data stands for exactly the clock after the strobe, zero otherwise;
   // the sub-second value is a live snapshot and may be mid-change
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         rdata_o <= 32'h0000_0000;
      end else if (rd_i) begin
         case (addr_i)
            ADDR_CTRL: begin
               rdata_o <= 32'h0000_0000;
               rdata_o[CTRL_EN_BIT] <= count_en_r;
               rdata_o[CTRL_FMT_BIT] <= hour_format_sel_r;
               rdata_o[CTRL_HSTAT_BIT] <= hold_stat_r;
               rdata_o[CTRL_HREQ_BIT] <= (hold_req_r == RTCCC_HELD);
            end
            ADDR_CORR: rdata_o <= {24'h00_0000, corr_r};
            ADDR_SUB: rdata_o <= {16'h0000, sub_r}; // [RULE7]
            ADDR_SEC: rdata_o <= {25'h000_0000, sec_r};
            ADDR_MIN: rdata_o <= {25'h000_0000, min_r};
            ADDR_HOUR: rdata_o <= {26'h000_0000, hour_r};
            ADDR_DAY: rdata_o <= {26'h000_0000, day_r};
            ADDR_WEEK: rdata_o <= {29'h0000_0000, week_r};
            default: rdata_o <= 32'h0000_0000;
         endcase
      end else begin
         rdata_o <= 32'h0000_0000;
      end
   end

endmodule // rtccc_chain

/* rtccc_chain_monitor.sv */
// Purpose: port assertions for the rtc counter chain
// Assumes: read data lands one cycle after the read strobe
// Notes: reserved bits are expected to read as zero
`timescale 1ns/100ps
module rtccc_chain_monitor
   import rtccc_pkg::*;
#(
   parameter int SUBSEC_COUNT = SUBSEC_COUNT_DEF
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // register port
   input wire logic [31:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   // calendar context
   input wire logic [4:0] month_bcd_i,
   input wire logic leap_year_i,
   input wire logic day_overflow_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // a read of a bcd counter never shows a value past its last count
   property bcd_max(logic [31:0] a, logic [31:0] hi);
      rd_i && addr_i == a |=> rdata_o <= hi && rdata_o[3:0] <= 4'h9;
   endproperty
   AST_SEC_RANGE: assert property (bcd_max(ADDR_SEC, 32'h59))
      else $error("seconds read out of range");
   AST_HOUR_RANGE: assert property (bcd_max(ADDR_HOUR, 32'h32))
      else $error("hours read out of range");
   AST_WEEK_RANGE: assert property (bcd_max(ADDR_WEEK, 32'h6))
      else $error("weekday read out of range");
   AST_DAY_RANGE: assert property (rd_i && addr_i == ADDR_DAY |=> rdata_o inside {[1:49]})
      else $error("day read out of range");
   AST_SUB_WIDTH: assert property (rd_i && addr_i == ADDR_SUB |=> rdata_o[31:16] == 16'h0)
      else $error("sub-second read wider than 16 bits");
   // the clear must land before the sub-second count can climb far
   AST_SEC_CLEARS_SUB: assert property (wr_i && addr_i == ADDR_SEC ##[1:2]
      rd_i && addr_i == ADDR_SUB |=> rdata_o < 32'h2)
      else $error("sub-second count not cleared by seconds write");
   AST_BAD_SEC: assert property (wr_i && addr_i == ADDR_SEC && wdata_i == 32'h60 ##[1:2]
      rd_i && addr_i == ADDR_SEC |=> rdata_o != 32'h60)
      else $error("illegal seconds value was stored");
   AST_DAY_PULSE: assert property (day_overflow_o |=> !day_overflow_o)
      else $error("day wrap pulse longer than one cycle");
   // main scenarios reached
   COV_WRAP: cover property (day_overflow_o);
   COV_SEC_WR: cover property (wr_i && addr_i == ADDR_SEC);
   COV_HOUR_RD: cover property (rd_i && addr_i == ADDR_HOUR);
endmodule // rtccc_chain_monitor

/* test_rtc_calendar_counter_chain.sv */
// Purpose: self-checking bench for the rtc counter chain
// Assumes: a 4-clock second keeps every rollover short
// Notes: counters are held before reads that must be exact
`timescale 1ns/100ps
module test_rtc_calendar_counter_chain;
   import rtccc_pkg::*;
   logic clk_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, leap_year_i = 1'b0;
   logic [31:0] addr_i = 32'h0, wdata_i = 32'h0, rdata_o;
   logic [4:0] month_bcd_i = 5'h01;
   logic day_overflow_o;
   int mismatches = 0, check_count = 0;
   // 200 MHz clock
   always #2.5 clk_i = ~clk_i;
   rtccc_chain #(.SUBSEC_COUNT(4)) u_rtccc_chain (.clk_i(clk_i), .nrst_i(nrst_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .month_bcd_i(month_bcd_i), .leap_year_i(leap_year_i), .day_overflow_o(day_overflow_o));
   // compare and count
   task automatic chk(input logic [31:0] s, e);
      check_count++;
      if (s !== e) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   // one-cycle write; the gap after it keeps strobes from merging
   task automatic wr(input logic [31:0] a, d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   // read, then judge the data in the cycle it stands
   task automatic rd(input logic [31:0] a, e);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      chk(rdata_o, e);
   endtask
   task automatic finish_test;
      if (mismatches == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // last second of a month's last day, then wait for the wrap
   task automatic day_wrap(input logic [4:0] m, input logic lp, input logic [31:0] last);
      bit seen = 1'b0;
      @(posedge clk_i);
      month_bcd_i <= m;
      leap_year_i <= lp;
      wr(ADDR_CTRL, 32'h8401);
      wr(ADDR_DAY, last);
      wr(ADDR_WEEK, 32'h6);
      wr(ADDR_HOUR, 32'h23);
      wr(ADDR_MIN, 32'h59);
      wr(ADDR_SEC, 32'h59);
      wr(ADDR_CTRL, 32'h8400);
      for (int i = 0; i < 20 && !seen; i++) begin
         @(negedge clk_i);
         seen = day_overflow_o;
      end
      chk({31'h0, seen}, 32'h1);
      if (!seen) finish_test();
      wr(ADDR_CTRL, 32'h8401);
      rd(ADDR_DAY, 32'h01);
      rd(ADDR_WEEK, 32'h0);
   endtask
   // setting c written at second 30, then start at s and count ticks for 8 clocks
   task automatic corr_sec(input logic [31:0] c, s, e);
      wr(ADDR_SEC, 32'h30);
      wr(ADDR_CORR, c);
      wr(ADDR_SEC, s);
      wr(ADDR_CTRL, 32'h8400);
      repeat (6) @(posedge clk_i);
      wr(ADDR_CTRL, 32'h8401);
      rd(ADDR_SEC, e);
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      nrst_i <= 1'b1;
      rd(ADDR_HOUR, 32'h12);
      rd(ADDR_DAY, 32'h01);
      rd(ADDR_SUB, 32'h0);
      rd(32'h4000_5240, 32'h0);
      wr(ADDR_SEC, 32'h60);
      rd(ADDR_SEC, 32'h0);
      wr(ADDR_MIN, 32'h5A);
      rd(ADDR_MIN, 32'h0);
      wr(ADDR_CTRL, 32'h8000);
      wr(ADDR_MIN, 32'h59);
      wr(ADDR_HOUR, 32'h11);
      wr(ADDR_SEC, 32'h59);
      repeat (6) @(posedge clk_i);
      wr(ADDR_CTRL, 32'h8001);
      rd(ADDR_HOUR, 32'h32);
      rd(ADDR_MIN, 32'h0);
      wr(ADDR_SEC, 32'h10);
      rd(ADDR_SUB, 32'h1);
      day_wrap(5'h04, 1'b0, 32'h30);
      day_wrap(5'h02, 1'b1, 32'h29);
      day_wrap(5'h02, 1'b0, 32'h28);
      day_wrap(5'h12, 1'b0, 32'h31);
      corr_sec(32'h7E, 32'h00, 32'h01);
      corr_sec(32'h02, 32'h40, 32'h43);
      corr_sec(32'hFE, 32'h20, 32'h22);
      corr_sec(32'h41, 32'h00, 32'h02);
      wr(ADDR_CTRL, 32'h8001);
      rd(ADDR_HOUR, 32'h12);
      rd(ADDR_CTRL, 32'h8003);
      finish_test();
   end
endmodule // test_rtc_calendar_counter_chain
bind rtccc_chain rtccc_chain_monitor #(.SUBSEC_COUNT(SUBSEC_COUNT)) u_rtccc_chain_monitor (
   .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .rd_i(rd_i), .rdata_o(rdata_o), .month_bcd_i(month_bcd_i), .leap_year_i(leap_year_i),
   .day_overflow_o(day_overflow_o));
